// ---- est_pkg.sv ----
// Contract
// - table holds up to 16 entries, each one delay and one exposure time.
// - after start, consecutive images use successive table entries' delay and exposure.
// - zero exposure entry is skipped and sequence restarts at entry zero.
// - active trigger mode applies to every image of the sequence.
// - pair count reports defined pairs, never above 16.
// - delay and exposure values are unsigned 32-bit in time-base units.
// - one exposure unit code for all entries: 0 ns, 1 us, 2 ms.
// - one delay unit code for all entries, same encoding.
// - trigger status true for high input with high polarity, false with low.
// - max-rate mode derives longest exposure from line time and vertical lines.
// - mode 0 starts automatically ignoring trigger; mode 1 needs force trigger.
// - mode 2 starts on selected trigger edge; mode 3 exposes for pulse width.
// - max-rate exposure time is always reported in nanoseconds.
package est_pkg;

  localparam int          TBL_DEPTH     = 16;
  localparam int          ADDR_W        = 12;
  localparam int          DATA_W        = 32;

  localparam logic [11:0] ADDR_CTRL     = 12'h000;
  localparam logic [11:0] ADDR_UNITS    = 12'h004;
  localparam logic [11:0] ADDR_STATUS   = 12'h008;
  localparam logic [11:0] ADDR_MAXTIME  = 12'h00C;
  localparam logic [11:0] ADDR_ROI      = 12'h010;
  localparam logic [11:0] ADDR_LINE     = 12'h014;
  localparam logic [11:0] ADDR_TBL_BASE = 12'h080;

  localparam int CTRL_RUN_BIT     = 0;
  localparam int CTRL_MAXRATE_BIT = 1;
  localparam int CTRL_FORCE_BIT   = 2;
  localparam int CTRL_MODE_LSB    = 4;
  localparam int UNITS_EXP_LSB    = 0;
  localparam int UNITS_DLY_LSB    = 8;
  localparam int STAT_LEVEL_BIT   = 0;
  localparam int STAT_BUSY_BIT    = 1;
  localparam int STAT_EXPOSE_BIT  = 2;
  localparam int STAT_IDX_LSB     = 4;
  localparam int STAT_COUNT_LSB   = 8;

  localparam logic [1:0] UNIT_NS = 2'h0;
  localparam logic [1:0] UNIT_US = 2'h1;
  localparam logic [1:0] UNIT_MS = 2'h2;

  localparam logic [1:0] MODE_AUTO  = 2'h0;
  localparam logic [1:0] MODE_SOFT  = 2'h1;
  localparam logic [1:0] MODE_EDGE  = 2'h2;
  localparam logic [1:0] MODE_WIDTH = 2'h3;

  localparam int          CLK_PERIOD_NS = 4;
  localparam int          NS_PER_US     = 1000;
  localparam int          NS_PER_MS     = 1000000;
  localparam logic [63:0] CYC_PER_US    = 64'(NS_PER_US / CLK_PERIOD_NS);
  localparam logic [63:0] CYC_PER_MS    = 64'(NS_PER_MS / CLK_PERIOD_NS);

  localparam logic [15:0] RST_ROI_LINES = 16'h0000;
  localparam logic [15:0] RST_LINE_NS   = 16'h0000;

  typedef enum logic [6:0] {
    S_IDLE    = 7'b0000001,
    S_FETCH   = 7'b0000010,
    S_CHECK   = 7'b0000100,
    S_ARM     = 7'b0001000,
    S_DELAY   = 7'b0010000,
    S_EXPOSE  = 7'b0100000,
    S_EXT_EXP = 7'b1000000
  } est_state_type;

  // ns rounds down to whole cycles; code 3 falls back to ns
  function automatic logic [63:0] est_cycles(input logic [31:0] v, input logic [1:0] c);
    logic [63:0] r;
    r = {34'h0, v[31:2]};
    if (c == UNIT_US) begin
      r = 64'(v) * CYC_PER_US;
    end else if (c == UNIT_MS) begin
      r = 64'(v) * CYC_PER_MS;
    end
    return r;
  endfunction

  function automatic logic [4:0] est_pair_count(input logic [15:0] nz);
    logic [4:0] n;
    n = 5'h10;
    for (int i = TBL_DEPTH - 1; i >= 0; i--) begin
      if (!nz[i]) begin
        n = 5'(i);
      end
    end
    return n;
  endfunction

endpackage

// ---- est_tbl_if.sv ----
`timescale 1ns/100ps
interface est_tbl_if;
  logic        we;
  logic [4:0]  waddr;
  logic [31:0] wdata;
  logic [4:0]  raddr_a;
  logic [31:0] rdata_a;
  logic [3:0]  raddr_b;
  logic [31:0] rdly_b;
  logic [31:0] rexp_b;
  modport mem  (input we, waddr, wdata, raddr_a, raddr_b, output rdata_a, rdly_b, rexp_b);
  modport user (output we, waddr, wdata, raddr_a, raddr_b, input rdata_a, rdly_b, rexp_b);
endinterface

// ---- est_table_mem.sv ----
`timescale 1ns/100ps
module est_table_mem (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  est_tbl_if.mem    tbl
);
  import est_pkg::*;

  // word 2n is delay of entry n, word 2n+1 its exposure
  logic [31:0] dly_mem [TBL_DEPTH];
  logic [31:0] exp_mem [TBL_DEPTH];
  logic [31:0] rdata_a_r;
  logic [31:0] rdly_b_r;
  logic [31:0] rexp_b_r;

  wire [3:0] wentry = tbl.waddr[4:1];
  wire [3:0] aentry = tbl.raddr_a[4:1];

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < TBL_DEPTH; i++) begin
        dly_mem[i] <= 32'h0;
        exp_mem[i] <= 32'h0;
      end
    end else if (tbl.we && tbl.waddr[0]) begin
      exp_mem[wentry] <= tbl.wdata;
    end else if (tbl.we) begin
      dly_mem[wentry] <= tbl.wdata;
    end
  end

  always_ff @(posedge clk_i) begin
    rdata_a_r <= tbl.raddr_a[0] ? exp_mem[aentry] : dly_mem[aentry];
    rdly_b_r  <= dly_mem[tbl.raddr_b];
    rexp_b_r  <= exp_mem[tbl.raddr_b];
  end

  assign tbl.rdata_a = rdata_a_r;
  assign tbl.rdly_b  = rdly_b_r;
  assign tbl.rexp_b  = rexp_b_r;
endmodule

// ---- est_sequencer.sv ----
`timescale 1ns/100ps
module est_sequencer (
  input  wire logic                       clk_i,
  input  wire logic                       rst_n_i,
  input  wire logic                       psel_i,
  input  wire logic                       penable_i,
  input  wire logic                       pwrite_i,
  input  wire logic [est_pkg::ADDR_W-1:0] paddr_i,
  input  wire logic [est_pkg::DATA_W-1:0] pwdata_i,
  output logic      [est_pkg::DATA_W-1:0] prdata_o,
  output logic                            pready_o,
  output logic                            pslverr_o,
  input  wire logic                       trig_i,
  input  wire logic                       trig_polarity_i,
  input  wire logic                       acq_enable_i,
  input  wire logic                       readout_busy_i,
  output logic                            exposure_o,
  output logic                            frame_start_o,
  output logic                            seq_busy_o,
  output logic                            trigger_level_status_o
);
  import est_pkg::*;

  est_tbl_if tbl ();

  est_table_mem u_mem (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .tbl     (tbl)
  );

  est_state_type st_r;
  est_state_type st_nxt;
  logic [3:0]    idx_r;
  logic [3:0]    idx_nxt;
  logic [63:0]   cnt_r;
  logic [63:0]   cnt_nxt;
  logic [1:0]    trig_sync_r;
  logic [1:0]    pol_sync_r;
  logic [1:0]    acq_sync_r;
  logic          lvl_prev_r;
  logic          run_r;
  logic          max_mode_r;
  logic          force_pend_r;
  logic [1:0]    trig_mode_r;
  logic [1:0]    exp_unit_r;
  logic [1:0]    dly_unit_r;
  logic [15:0]   roi_lines_r;
  logic [15:0]   line_ns_r;
  logic [31:0]   max_time_r;
  logic [15:0]   nonzero_r;
  logic [31:0]   prdata_r;
  logic          pready_r;
  logic          pslverr_r;
  logic          exposure_r;
  logic          frame_start_r;
  logic          busy_r;
  logic          trig_status_r;

  // pins: only the second stage of each synchroniser is read
  wire lvl_now   = trig_sync_r[1] ~^ pol_sync_r[1];
  wire trig_edge = lvl_now & ~lvl_prev_r;
  wire acq_en    = acq_sync_r[1];

  // bus decode; every access takes two access cycles for the table read
  wire acc       = psel_i & penable_i;
  wire acc_first = acc & ~pready_r;
  wire wr_fire   = acc & pready_r & pwrite_i;
  wire sel_ctrl  = paddr_i == ADDR_CTRL;
  wire sel_units = paddr_i == ADDR_UNITS;
  wire sel_stat  = paddr_i == ADDR_STATUS;
  wire sel_max   = paddr_i == ADDR_MAXTIME;
  wire sel_roi   = paddr_i == ADDR_ROI;
  wire sel_line  = paddr_i == ADDR_LINE;
  wire sel_tbl   = paddr_i[11:7] == ADDR_TBL_BASE[11:7];
  wire mapped    = sel_ctrl | sel_units | sel_stat | sel_max | sel_roi | sel_line | sel_tbl;
  wire tbl_exp_w = wr_fire & sel_tbl & paddr_i[2];
  wire force_set = wr_fire & sel_ctrl & pwdata_i[CTRL_FORCE_BIT];

  wire [4:0]  pair_cnt = est_pair_count(nonzero_r);
  wire [31:0] max_prod = 32'(roi_lines_r) * 32'(line_ns_r);

  wire [31:0] rd_ctrl  = (32'(run_r) << CTRL_RUN_BIT) | (32'(max_mode_r) << CTRL_MAXRATE_BIT)
                       | (32'(trig_mode_r) << CTRL_MODE_LSB);
  wire [31:0] rd_units = (32'(exp_unit_r) << UNITS_EXP_LSB) | (32'(dly_unit_r) << UNITS_DLY_LSB);
  wire [31:0] rd_stat  = (32'(trig_status_r) << STAT_LEVEL_BIT) | (32'(busy_r) << STAT_BUSY_BIT)
                       | (32'(exposure_r) << STAT_EXPOSE_BIT) | (32'(idx_r) << STAT_IDX_LSB)
                       | (32'(pair_cnt) << STAT_COUNT_LSB);
  wire [31:0] rd_mux   = sel_ctrl  ? rd_ctrl :
                         sel_units ? rd_units :
                         sel_stat  ? rd_stat :
                         sel_max   ? max_time_r :
                         sel_roi   ? 32'(roi_lines_r) :
                         sel_line  ? 32'(line_ns_r) :
                         sel_tbl   ? tbl.rdata_a : 32'h0;

  assign tbl.we      = wr_fire & sel_tbl;
  assign tbl.waddr   = paddr_i[6:2];
  assign tbl.wdata   = pwdata_i;
  assign tbl.raddr_a = paddr_i[6:2];
  assign tbl.raddr_b = idx_r;

  // one unit code per field covers the whole table
  wire [63:0] dly_cyc  = est_cycles(tbl.rdly_b, dly_unit_r);
  wire [63:0] max_cyc  = est_cycles(max_time_r, UNIT_NS);
  wire [63:0] tbl_cyc  = est_cycles(tbl.rexp_b, exp_unit_r);
  wire [63:0] exp_cyc  = max_mode_r ? max_cyc : tbl_cyc;
  wire        cnt_done = cnt_r <= 64'h1;

  // software force trigger stays effective regardless of acquire enable in modes 1 and 2; modes 0 and 3 ignore it
  wire start_go = (trig_mode_r == MODE_AUTO) ? (acq_en & ~readout_busy_i) :
                  (trig_mode_r == MODE_SOFT) ? force_pend_r :
                  (trig_mode_r == MODE_EDGE) ? ((trig_edge & acq_en) | force_pend_r) :
                  (trig_edge & acq_en);

  always_comb begin
    st_nxt  = st_r;
    idx_nxt = idx_r;
    cnt_nxt = cnt_r;
    unique case (st_r)
      S_IDLE: begin
        if (run_r) begin
          st_nxt  = S_FETCH;
          idx_nxt = 4'h0;
        end
      end
      S_FETCH: begin
        st_nxt = S_CHECK;
      end
      S_CHECK: begin
        if (!run_r) begin
          st_nxt = S_IDLE;
        end else if (!nonzero_r[idx_r]) begin
          st_nxt  = S_FETCH;
          idx_nxt = 4'h0;
        end else begin
          st_nxt = S_ARM;
        end
      end
      S_ARM: begin
        if (!run_r) begin
          st_nxt = S_IDLE;
        end else if (start_go && trig_mode_r == MODE_WIDTH) begin
          st_nxt = S_EXT_EXP;
        end else if (start_go) begin
          st_nxt  = S_DELAY;
          cnt_nxt = dly_cyc;
        end
      end
      S_DELAY: begin
        if (cnt_done) begin
          st_nxt  = S_EXPOSE;
          cnt_nxt = exp_cyc;
        end else begin
          cnt_nxt = cnt_r - 64'h1;
        end
      end
      S_EXPOSE: begin
        if (cnt_done) begin
          st_nxt  = S_FETCH;
          idx_nxt = idx_r + 4'h1;
        end else begin
          cnt_nxt = cnt_r - 64'h1;
        end
      end
      S_EXT_EXP: begin
        if (!lvl_now) begin
          st_nxt  = S_FETCH;
          idx_nxt = idx_r + 4'h1;
        end
      end
      default: begin
        st_nxt = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      trig_sync_r <= 2'h0;
      pol_sync_r  <= 2'h0;
      acq_sync_r  <= 2'h0;
      lvl_prev_r  <= 1'b1; // cleared synchronisers read as high level; avoids a false edge
    end else begin
      trig_sync_r <= {trig_sync_r[0], trig_i};
      pol_sync_r  <= {pol_sync_r[0], trig_polarity_i};
      acq_sync_r  <= {acq_sync_r[0], acq_enable_i};
      lvl_prev_r  <= lvl_now;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_r  <= S_IDLE;
      idx_r <= 4'h0;
      cnt_r <= 64'h0;
    end else begin
      st_r  <= st_nxt;
      idx_r <= idx_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      run_r       <= 1'b0;
      max_mode_r  <= 1'b0;
      trig_mode_r <= MODE_AUTO;
    end else if (wr_fire && sel_ctrl) begin
      run_r       <= pwdata_i[CTRL_RUN_BIT];
      max_mode_r  <= pwdata_i[CTRL_MAXRATE_BIT];
      trig_mode_r <= pwdata_i[CTRL_MODE_LSB +: 2];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      exp_unit_r <= UNIT_NS;
      dly_unit_r <= UNIT_NS;
    end else if (wr_fire && sel_units) begin
      exp_unit_r <= pwdata_i[UNITS_EXP_LSB +: 2];
      dly_unit_r <= pwdata_i[UNITS_DLY_LSB +: 2];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      roi_lines_r <= RST_ROI_LINES;
      line_ns_r   <= RST_LINE_NS;
      max_time_r  <= 32'h0;
    end else begin
      roi_lines_r <= (wr_fire && sel_roi) ? pwdata_i[15:0] : roi_lines_r;
      line_ns_r   <= (wr_fire && sel_line) ? pwdata_i[15:0] : line_ns_r;
      max_time_r  <= max_prod;
    end
  end

  // a new force request in the consuming cycle survives
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      force_pend_r <= 1'b0;
    end else begin
      force_pend_r <= force_set | (force_pend_r & ~(st_r == S_ARM && start_go));
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      nonzero_r <= 16'h0000;
    end else if (tbl_exp_w) begin
      nonzero_r[paddr_i[6:3]] <= |pwdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      prdata_r  <= 32'h0;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      prdata_r  <= (acc_first && !pwrite_i && mapped) ? rd_mux : 32'h0;
      pready_r  <= acc_first;
      pslverr_r <= acc_first & ~mapped;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      exposure_r    <= 1'b0;
      frame_start_r <= 1'b0;
      busy_r        <= 1'b0;
      trig_status_r <= 1'b0;
    end else begin
      exposure_r    <= (st_nxt == S_EXPOSE) | (st_nxt == S_EXT_EXP);
      frame_start_r <= ((st_nxt == S_EXPOSE) && (st_r != S_EXPOSE)) | ((st_nxt == S_EXT_EXP) && (st_r != S_EXT_EXP));
      busy_r        <= st_nxt != S_IDLE;
      trig_status_r <= lvl_now;
    end
  end

  assign prdata_o               = prdata_r;
  assign pready_o               = pready_r;
  assign pslverr_o              = pslverr_r;
  assign exposure_o             = exposure_r;
  assign frame_start_o          = frame_start_r;
  assign seq_busy_o             = busy_r;
  assign trigger_level_status_o = trig_status_r;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  wire in_expose = st_r == S_EXPOSE;

  sequence s_arm_go;
    st_r == S_ARM && run_r && start_go;
  endsequence

  sequence s_delay_done;
    st_r == S_DELAY && cnt_done;
  endsequence

  sequence s_expose_done;
    st_r == S_EXPOSE && cnt_done;
  endsequence

  chk_table_wrap: assert property (s_expose_done ##0 idx_r == 4'hF |=> idx_r == 4'h0)
    else $error("index did not wrap after sixteenth entry");
  chk_entry_advance: assert property (s_expose_done |=> st_r == S_FETCH && idx_r == $past(idx_r) + 4'h1)
    else $error("entry did not advance after exposure");
  chk_zero_restart: assert property (st_r == S_CHECK && run_r && !nonzero_r[idx_r] |=> st_r == S_FETCH && idx_r == 4'h0)
    else $error("zero exposure entry did not restart sequence");
  chk_arm_every: assert property (st_r == S_CHECK && run_r && nonzero_r[idx_r] |=> st_r == S_ARM)
    else $error("image not armed for trigger");
  chk_count_bound: assert property (pair_cnt <= 5'h10 && ((&nonzero_r) == (pair_cnt == 5'h10)))
    else $error("pair count out of range");
  chk_exp_units: assert property (s_delay_done ##0 !max_mode_r |=> in_expose && cnt_r == $past(tbl_cyc))
    else $error("exposure count not scaled by unit");
  chk_dly_units: assert property (s_arm_go ##0 trig_mode_r != MODE_WIDTH |=> st_r == S_DELAY && cnt_r == $past(dly_cyc))
    else $error("delay count not scaled by unit");
  chk_level_high: assert property (trig_sync_r[1] && pol_sync_r[1] |=> trig_status_r)
    else $error("trigger status false for high input and high polarity");
  chk_level_inv: assert property (trig_sync_r[1] && !pol_sync_r[1] |=> !trig_status_r)
    else $error("trigger status true for high input and low polarity");
  chk_level_low: assert property (!trig_sync_r[1] && !pol_sync_r[1] |=> trig_status_r)
    else $error("trigger status false for low input and low polarity");
  chk_max_rate_ns: assert property (s_delay_done ##0 max_mode_r |=> cnt_r == $past(max_cyc))
    else $error("max rate exposure not taken in nanoseconds");
  chk_max_rate_calc: assert property ($changed(max_prod) |=> max_time_r == $past(max_prod) ##1 max_time_r == $past(max_prod, 2))
    else $error("max rate time not tracking line geometry");
  chk_auto_start: assert property (st_r == S_ARM && run_r && trig_mode_r == MODE_AUTO && acq_en && !readout_busy_i |=> st_r == S_DELAY)
    else $error("auto trigger did not start");
  chk_soft_wait: assert property (st_r == S_ARM && trig_mode_r == MODE_SOFT && !force_pend_r |=> st_r != S_DELAY)
    else $error("soft mode started without force");
  chk_edge_start: assert property (st_r == S_ARM && run_r && trig_mode_r == MODE_EDGE && trig_edge && acq_en |=> st_r == S_DELAY)
    else $error("trigger edge did not start sequence");
  chk_width_hold: assert property (st_r == S_EXT_EXP && lvl_now |=> st_r == S_EXT_EXP && exposure_r)
    else $error("pulse width exposure ended early");
  chk_delay_first: assert property ($rose(in_expose) |-> $past(st_r) == S_DELAY && !$past(exposure_r))
    else $error("exposure started without delay");
endmodule

// ---- est_sensor_model.sv ----
`timescale 1ns/100ps
module est_sensor_model #(
  parameter int READ_CYC = 6
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic exposure_i,
  output logic      readout_busy_o
);
  logic       exp_d_r;
  logic [7:0] cnt_r;
  // readout starts as each exposure ends; holding busy delays the next auto start
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      exp_d_r <= 1'b0;
      cnt_r   <= 8'h00;
    end else begin
      exp_d_r <= exposure_i;
      if (exp_d_r && !exposure_i) begin
        cnt_r <= 8'(READ_CYC);
      end else if (cnt_r != 8'h00) begin
        cnt_r <= cnt_r - 8'h01;
      end
    end
  end
  assign readout_busy_o = (cnt_r != 8'h00);
endmodule

// ---- exposure_sequence_table_tb.sv ----
`timescale 1ns/100ps
module exposure_sequence_table_tb;
  import est_pkg::*;
  logic        clk_i, rst_n_i, psel, penable, pwrite, trig, pol, acq, rbusy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, exposure, fstart, sbusy, tstat;
  int          n_mismatch, tests_run, w, g;

  est_sequencer uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .trig_i(trig), .trig_polarity_i(pol), .acq_enable_i(acq),
    .readout_busy_i(rbusy), .exposure_o(exposure), .frame_start_o(fstart), .seq_busy_o(sbusy),
    .trigger_level_status_o(tstat));
  est_sensor_model sensor (.clk_i(clk_i), .rst_n_i(rst_n_i), .exposure_i(exposure),
    .readout_busy_o(rbusy));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic test_done();
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic lost(input string what);
    n_mismatch++;
    $display("ERROR %s expected done seen timeout", what);
    test_done();
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge clk_i);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    if (n >= 20) lost("pready");
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask
  task automatic rdc(input string what, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    rd(a, q);
    chk(what, exp, q);
  endtask
  // one image: low cycles before it in gap, high cycles in width
  task automatic expo(output int width, output int gap);
    gap   = 0;
    width = 0;
    do begin
      @(posedge clk_i);
      gap++;
    end while (exposure !== 1'b1 && gap < 3000);
    if (gap >= 3000) lost("exposure start");
    chk("frame_start", 32'h1, {31'h0, fstart});
    do begin
      @(posedge clk_i);
      width++;
    end while (exposure === 1'b1 && width < 3000);
  endtask
  task automatic quiet(input string what, input int n);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      @(posedge clk_i);
      if (exposure !== 1'b0) seen = 1'b1;
    end
    chk(what, 32'h0, {31'h0, seen});
  endtask
  task automatic stop();
    int n;
    wr(ADDR_CTRL, 32'h0);
    n = 0;
    while (sbusy !== 1'b0 && n < 1000) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 1000) lost("sequencer stop");
  endtask
  task automatic tbl(input int i, input logic [31:0] dly, input logic [31:0] ex);
    wr(ADDR_TBL_BASE + 12'(8 * i), dly);
    wr(ADDR_TBL_BASE + 12'(8 * i + 4), ex);
  endtask

  task automatic s_reset();
    logic [31:0] q;
    logic        e;
    chk("idle outputs", 32'h0, {29'h0, exposure, fstart, sbusy});
    rdc("roi reset", ADDR_ROI, 32'h0);
    rdc("line reset", ADDR_LINE, 32'h0);
    rdc("maxtime reset", ADDR_MAXTIME, 32'h0);
    apb(1'b0, 12'h040, 32'h0, q, e);
    chk("unmapped error", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, q);
  endtask
  task automatic s_table();
    logic [31:0] q;
    for (int i = 0; i < TBL_DEPTH; i++) tbl(i, 32'h8, 32'hC);
    rd(ADDR_STATUS, q);
    chk("pair count full", 32'h10, {27'h0, q[12:8]});
    wr(ADDR_CTRL, 32'h1);
    for (int k = 0; k <= TBL_DEPTH; k++) begin
      expo(w, g);
      chk("full table width", 32'h3, 32'(w));
    end
    stop();
    tbl(1, 32'h28, 32'h14);
    rdc("table delay", ADDR_TBL_BASE + 12'h8, 32'h28);
    tbl(2, 32'h8, 32'h0);
    rd(ADDR_STATUS, q);
    chk("pair count two", 32'h2, {27'h0, q[12:8]});
  endtask
  task automatic s_auto();
    int ew [4] = '{3, 5, 3, 5};
    int dl [4] = '{2, 10, 2, 10};
    wr(ADDR_UNITS, 32'h0);
    acq <= 1'b1;
    wr(ADDR_CTRL, 32'h1);
    for (int k = 0; k < 4; k++) begin
      expo(w, g);
      chk("auto width", 32'(ew[k]), 32'(w));
      if (k > 0) chk("delay before exposure", 32'h1, {31'h0, g > dl[k]});
    end
    stop();
  endtask
  task automatic s_units();
    tbl(1, 32'h8, 32'h0);
    tbl(0, 32'h1, 32'h1);
    wr(ADDR_UNITS, 32'h101);
    wr(ADDR_CTRL, 32'h1);
    expo(w, g);
    chk("us delay", 32'h1, {31'h0, g >= 250});
    chk("us exposure", 32'd250, 32'(w));
    stop();
    for (int c = 0; c < 3; c++) begin
      wr(ADDR_UNITS, 32'(c * 257));
      rdc("unit codes", ADDR_UNITS, 32'(c * 257));
    end
    wr(ADDR_UNITS, 32'h0);
    tbl(0, 32'h8, 32'hC);
  endtask
  task automatic s_soft();
    wr(ADDR_CTRL, 32'h11);
    quiet("soft no force", 40);
    rdc("ctrl readback", ADDR_CTRL, 32'h11);
    wr(ADDR_CTRL, 32'h15);
    expo(w, g);
    chk("soft width", 32'h3, 32'(w));
    quiet("soft second image", 40);
    stop();
  endtask
  task automatic s_edge();
    wr(ADDR_CTRL, 32'h21);
    quiet("edge no trigger", 30);
    trig <= 1'b1;
    expo(w, g);
    chk("edge width", 32'h3, 32'(w));
    quiet("level holds no image", 30);
    trig <= 1'b0;
    quiet("wrong edge", 30);
    acq  <= 1'b0;
    trig <= 1'b1;
    quiet("acquire disabled", 30);
    trig <= 1'b0;
    acq  <= 1'b1;
    repeat (6) @(posedge clk_i);
    trig <= 1'b1;
    expo(w, g);
    chk("edge second image", 32'h3, 32'(w));
    trig <= 1'b0;
    stop();
  endtask
  task automatic s_width();
    wr(ADDR_CTRL, 32'h31);
    // the edge must land while armed, not during fetch or check
    repeat (6) @(posedge clk_i);
    fork
      begin
        trig <= 1'b1;
        repeat (20) @(posedge clk_i);
        trig <= 1'b0;
      end
      expo(w, g);
    join
    chk("pulse width exposure", 32'h1, {31'h0, w >= 19 && w <= 21});
    stop();
  endtask
  task automatic s_level();
    logic [31:0] q;
    for (int k = 0; k < 4; k++) begin
      trig <= k[0];
      pol  <= k[1];
      repeat (6) @(posedge clk_i);
      chk("level status", {31'h0, ~(k[0] ^ k[1])}, {31'h0, tstat});
      rd(ADDR_STATUS, q);
      chk("level status reg", {31'h0, ~(k[0] ^ k[1])}, {31'h0, q[0]});
    end
    trig <= 1'b0;
    pol  <= 1'b1;
  endtask
  task automatic s_maxrate();
    wr(ADDR_ROI, 32'hA);
    wr(ADDR_LINE, 32'h28);
    rdc("max rate time", ADDR_MAXTIME, 32'd400);
    wr(ADDR_CTRL, 32'h3);
    expo(w, g);
    chk("max rate width", 32'd100, 32'(w));
    stop();
  endtask

  initial begin
    n_mismatch = 0;
    tests_run  = 0;
    rst_n_i    = 1'b0;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = 12'h000;
    pwdata     = 32'h0;
    trig       = 1'b0;
    pol        = 1'b1;
    acq        = 1'b1;
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    s_reset();
    s_table();
    s_auto();
    s_units();
    s_soft();
    s_edge();
    s_width();
    s_level();
    s_maxrate();
    test_done();
  end
endmodule
